// File: inc/pmcs_pkg.sv
// Contract
// - a new clock source select switches the system clock once that source runs.
// - sleep with cpu halt select 0 enters sleep; cpu and peripheral clocks stop.
// - sleep with cpu halt select 1 enters halt; peripherals clocked, cpu not.
// - halt select is sampled at the very cycle the sleep instruction executes.
// - run modes clock cpu and peripherals; select 00 primary, 01 secondary, 1x internal.
// - after reset the block starts in primary run on the primary oscillator.
// - secondary run stops primary, sets secondary running, clears primary ready.
// - select 01 without go or timer enable waits until go or timer enable and secondary ready.
// - secondary to primary keeps secondary clock until primary ready, then flags swap.
// - upper select bit set enters internal run; primary stops, primary ready clears.
// - internal frequency select is writable any time and applies at once.
// - frequency zero and source bit clear: fast internal output off, low oscillator clocks.
// - enabled internal output keeps clocking while settling; stable flag after settle time.
// - an internal oscillator already stable keeps its stable flag set.
// - stable flag decode: none when disabled, medium select picks medium or high flag.
// - internal to primary keeps internal clock until primary ready, then flags swap.
// - low frequency oscillator keeps running when watchdog or fail-safe monitor enabled.
// - automatic switches never change halt select or clock source select.
// - each source transition takes two to four oscillator periods.
// - entering or leaving internal run always incurs the switch delay.
// - primary ready reads 0 whenever clocked from a non-primary source.
package pmcs_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int INT_SETTLE_NS = 2000;
	localparam int INT_SETTLE_CYCLES = (INT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SETTLE_LAST = 8'(INT_SETTLE_CYCLES);
	localparam logic [7:0] SWITCH_LAST = 8'h02;
	localparam logic [5:0] OSC_CONTROL_IDX = 6'h00;
	localparam logic [5:0] OSC_CONTROL_TWO_IDX = 6'h01;
	localparam logic [5:0] AUX_CONTROL_IDX = 6'h02;
	localparam logic [5:0] MODE_STATUS_IDX = 6'h03;
	localparam logic [1:0] SRC_PRI = 2'h0;
	localparam logic [1:0] SRC_SEC = 2'h1;
	localparam logic [1:0] SRC_INT = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int HALT_BIT = 7;
	localparam int FREQ_LSB = 4;
	localparam int PRI_RDY_BIT = 3;
	localparam int HF_FLAG_BIT = 2;
	localparam int SECONDARY_RUN_STATE_BIT = 6;
	localparam int MED_SEL_BIT = 4;
	localparam int GO_BIT = 3;
	localparam int MED_FLAG_BIT = 1;
	localparam int INT_SRC_BIT = 0;
	localparam int TMR_EN_BIT = 1;
	localparam int WDT_EN_BIT = 2;
	localparam int FAILSAFE_CLOCK_MONITOR_EN_BIT = 3;
	localparam logic [1:0] RST_CS = 2'h0;
	localparam logic [2:0] RST_FREQ = 3'h0;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_SWITCH = 4'h2,
		ST_HALT = 4'h4,
		ST_SLEEP = 4'h8
	} pmcs_state_type;
endpackage : pmcs_pkg

// File: rtl/pmcs_top.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
module pmcs_top (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_exec,
	input wire logic wake_event,
	input wire logic primary_osc_ready,
	input wire logic secondary_osc_ready,
	output logic cpu_clock_enable,
	output logic periph_clock_enable,
	output logic [1:0] system_clock_select,
	output logic primary_osc_enable,
	output logic secondary_osc_enable,
	output logic high_freq_internal_enable,
	output logic low_freq_internal_enable,
	output logic [2:0] internal_freq_out,
	output logic medium_source_out
);
	import pmcs_pkg::*;

	typedef struct packed {
		pmcs_state_type st;
		logic [1:0] src;
		logic [1:0] pend;
		logic [7:0] cnt;
		logic [7:0] settle;
		logic stable;
		logic cpu_halt_select;
		logic [2:0] internal_freq_select;
		logic [1:0] clock_source_select;
		logic medium_source_select;
		logic secondary_osc_go;
		logic internal_source_select;
		logic timer_secondary_osc_enable;
		logic watchdog_enable;
		logic failsafe_enable;
		logic aw_got;
		logic [5:0] aw_idx;
		logic w_got;
		logic [7:0] w_byte;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic cpu_en;
		logic per_en;
		logic [1:0] clk_sel;
		logic pri_en;
		logic sec_en;
		logic hf_en;
		logic lf_en;
	} pmcs_regs_type;

	pmcs_regs_type r_q;
	pmcs_regs_type r_d;

	// ------------------------------------------------------------
	// mode and clock source control
	// ------------------------------------------------------------
	logic [1:0] target;
	logic target_ready;
	logic sec_armed;
	logic hf_req;
	logic asleep;
	logic primary_ready_flag;
	logic secondary_running_flag;
	logic high_internal_stable_flag;
	logic medium_internal_stable_flag;
	logic [7:0] ctl_one;
	logic [7:0] ctl_two;
	logic [7:0] ctl_aux;
	logic [7:0] mode_status;

	always_comb begin
		sec_armed = r_q.secondary_osc_go | r_q.timer_secondary_osc_enable;
		// the lower select bit is ignored once the upper one is set
		if (r_q.clock_source_select[1]) begin
			target = SRC_INT;
		end else if (r_q.clock_source_select[0]) begin
			// without an armed and running secondary oscillator, stay put
			target = (sec_armed && secondary_osc_ready) ? SRC_SEC : r_q.src;
		end else begin
			target = SRC_PRI;
		end
		case (target)
			// old clock keeps running until the primary reports ready
			SRC_PRI: target_ready = primary_osc_ready;
			SRC_SEC: target_ready = secondary_osc_ready;
			default: target_ready = 1'b1;
		endcase
		hf_req = (r_q.internal_freq_select != RST_FREQ) | r_q.internal_source_select;
		asleep = r_q.st == ST_SLEEP;
		// sleep clears every clock source status bit
		primary_ready_flag = !asleep && r_q.src == SRC_PRI;
		secondary_running_flag = !asleep && r_q.src == SRC_SEC;
		// flags vanish once the primary has taken over again
		high_internal_stable_flag = 1'b0;
		medium_internal_stable_flag = 1'b0;
		if (!asleep && r_q.stable && r_q.src != SRC_PRI) begin
			// only one stable flag at a time, chosen by the medium select bit
			if (r_q.medium_source_select) begin
				medium_internal_stable_flag = 1'b1;
			end else begin
				high_internal_stable_flag = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// register read words; unused bits read as zero
		// ------------------------------------------------------------
		ctl_one = 8'h00;
		ctl_one[HALT_BIT] = r_q.cpu_halt_select;
		ctl_one[FREQ_LSB +: 3] = r_q.internal_freq_select;
		ctl_one[PRI_RDY_BIT] = primary_ready_flag;
		ctl_one[HF_FLAG_BIT] = high_internal_stable_flag;
		ctl_one[1:0] = r_q.clock_source_select;
		ctl_two = 8'h00;
		ctl_two[SECONDARY_RUN_STATE_BIT] = secondary_running_flag;
		ctl_two[MED_SEL_BIT] = r_q.medium_source_select;
		ctl_two[GO_BIT] = r_q.secondary_osc_go;
		ctl_two[MED_FLAG_BIT] = medium_internal_stable_flag;
		ctl_aux = 8'h00;
		ctl_aux[INT_SRC_BIT] = r_q.internal_source_select;
		ctl_aux[TMR_EN_BIT] = r_q.timer_secondary_osc_enable;
		ctl_aux[WDT_EN_BIT] = r_q.watchdog_enable;
		ctl_aux[FAILSAFE_CLOCK_MONITOR_EN_BIT] = r_q.failsafe_enable;
		mode_status = {r_q.src, r_q.pend, r_q.st};
	end

	always_comb begin
		r_d = r_q;

		// ------------------------------------------------------------
		// power mode sequencing
		// ------------------------------------------------------------
		case (r_q.st)
			ST_RUN: begin
				if (sleep_exec) begin
					// the halt select seen in this very cycle picks the mode
					r_d.st = r_q.cpu_halt_select ? ST_HALT : ST_SLEEP;
				end else if (target != r_q.src && target_ready) begin
					r_d.st = ST_SWITCH;
					r_d.pend = target;
					r_d.cnt = SWITCH_LAST;
				end
			end
			ST_SWITCH: begin
				// only the state, source and count move; select and halt bits stay as written
				if (r_q.cnt == 8'h00) begin
					r_d.src = r_q.pend;
					r_d.st = ST_RUN;
				end else begin
					r_d.cnt = r_q.cnt - 8'h01;
				end
			end
			ST_HALT: begin
				if (wake_event) begin
					r_d.st = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (wake_event) begin
					r_d.st = ST_RUN;
				end
			end
			default: begin
				r_d.st = ST_RUN;
			end
		endcase

		// ------------------------------------------------------------
		// internal oscillator settling; an already stable one stays stable
		// ------------------------------------------------------------
		if (!hf_req || asleep) begin
			r_d.settle = 8'h00;
			r_d.stable = 1'b0;
		end else if (!r_q.stable) begin
			if (r_q.settle == SETTLE_LAST) begin
				r_d.stable = 1'b1;
			end else begin
				r_d.settle = r_q.settle + 8'h01;
			end
		end

		// ------------------------------------------------------------
		// clock gating and oscillator enables
		// ------------------------------------------------------------
		// clock gating is dropped for the whole switch so no runt edge escapes
		case (r_d.st)
			ST_RUN: begin
				r_d.cpu_en = 1'b1;
				r_d.per_en = 1'b1;
			end
			ST_HALT: begin
				r_d.cpu_en = 1'b0;
				r_d.per_en = 1'b1;
			end
			ST_SLEEP: begin
				r_d.cpu_en = 1'b0;
				r_d.per_en = 1'b0;
			end
			default: begin
				r_d.cpu_en = 1'b0;
				r_d.per_en = 1'b0;
			end
		endcase
		r_d.clk_sel = r_d.src;
		r_d.pri_en = r_d.st != ST_SLEEP && (r_d.src == SRC_PRI || target == SRC_PRI);
		r_d.sec_en = sec_armed || (r_d.st != ST_SLEEP && r_d.src == SRC_SEC);
		r_d.hf_en = hf_req && r_d.st != ST_SLEEP;
		r_d.lf_en = r_q.watchdog_enable || r_q.failsafe_enable
			|| (r_d.st != ST_SLEEP && r_d.src == SRC_INT && !hf_req);

		// ------------------------------------------------------------
		// axi4-lite write channel
		// ------------------------------------------------------------
		if (s_axi_awvalid && r_q.awready) begin
			r_d.aw_got = 1'b1;
			r_d.aw_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && r_q.wready) begin
			r_d.w_got = 1'b1;
			r_d.w_byte = s_axi_wdata[7:0];
			r_d.w_lane0 = s_axi_wstrb[0];
		end
		if (r_q.bvalid && s_axi_bready) begin
			r_d.bvalid = 1'b0;
		end
		if (r_q.aw_got && r_q.w_got && !r_q.bvalid) begin
			r_d.aw_got = 1'b0;
			r_d.w_got = 1'b0;
			r_d.bvalid = 1'b1;
			r_d.bresp = RESP_OKAY;
			case (r_q.aw_idx)
				OSC_CONTROL_IDX: begin
					if (r_q.w_lane0) begin
						r_d.cpu_halt_select = r_q.w_byte[HALT_BIT];
						r_d.internal_freq_select = r_q.w_byte[FREQ_LSB +: 3];
						r_d.clock_source_select = r_q.w_byte[1:0];
					end
				end
				OSC_CONTROL_TWO_IDX: begin
					if (r_q.w_lane0) begin
						r_d.medium_source_select = r_q.w_byte[MED_SEL_BIT];
						r_d.secondary_osc_go = r_q.w_byte[GO_BIT];
					end
				end
				AUX_CONTROL_IDX: begin
					if (r_q.w_lane0) begin
						r_d.internal_source_select = r_q.w_byte[INT_SRC_BIT];
						r_d.timer_secondary_osc_enable = r_q.w_byte[TMR_EN_BIT];
						r_d.watchdog_enable = r_q.w_byte[WDT_EN_BIT];
						r_d.failsafe_enable = r_q.w_byte[FAILSAFE_CLOCK_MONITOR_EN_BIT];
					end
				end
				MODE_STATUS_IDX: begin
				end
				default: begin
					r_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		r_d.awready = !r_d.aw_got && !r_d.bvalid;
		r_d.wready = !r_d.w_got && !r_d.bvalid;

		// ------------------------------------------------------------
		// axi4-lite read channel
		// ------------------------------------------------------------
		if (r_q.rvalid && s_axi_rready) begin
			r_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r_q.arready) begin
			r_d.rvalid = 1'b1;
			r_d.rresp = RESP_OKAY;
			case (s_axi_araddr[7:2])
				OSC_CONTROL_IDX: r_d.rdata = {24'h000000, ctl_one};
				OSC_CONTROL_TWO_IDX: r_d.rdata = {24'h000000, ctl_two};
				AUX_CONTROL_IDX: r_d.rdata = {24'h000000, ctl_aux};
				MODE_STATUS_IDX: r_d.rdata = {24'h000000, mode_status};
				default: begin
					r_d.rdata = 32'h00000000;
					r_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		r_d.arready = !r_d.rvalid;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r_q.st <= ST_RUN;
			r_q.src <= SRC_PRI;
			r_q.pend <= SRC_PRI;
			r_q.cnt <= 8'h00;
			r_q.settle <= 8'h00;
			r_q.stable <= 1'b0;
			r_q.cpu_halt_select <= 1'b0;
			r_q.internal_freq_select <= RST_FREQ;
			r_q.clock_source_select <= RST_CS;
			r_q.medium_source_select <= 1'b0;
			r_q.secondary_osc_go <= 1'b0;
			r_q.internal_source_select <= 1'b0;
			r_q.timer_secondary_osc_enable <= 1'b0;
			r_q.watchdog_enable <= 1'b0;
			r_q.failsafe_enable <= 1'b0;
			r_q.aw_got <= 1'b0;
			r_q.aw_idx <= 6'h00;
			r_q.w_got <= 1'b0;
			r_q.w_byte <= 8'h00;
			r_q.w_lane0 <= 1'b0;
			r_q.awready <= 1'b1;
			r_q.wready <= 1'b1;
			r_q.bvalid <= 1'b0;
			r_q.bresp <= RESP_OKAY;
			r_q.arready <= 1'b1;
			r_q.rvalid <= 1'b0;
			r_q.rdata <= 32'h00000000;
			r_q.rresp <= RESP_OKAY;
			r_q.cpu_en <= 1'b1;
			r_q.per_en <= 1'b1;
			r_q.clk_sel <= SRC_PRI;
			r_q.pri_en <= 1'b1;
			r_q.sec_en <= 1'b0;
			r_q.hf_en <= 1'b0;
			r_q.lf_en <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// outputs straight from the state register
	// ------------------------------------------------------------
	assign s_axi_awready = r_q.awready;
	assign s_axi_wready = r_q.wready;
	assign s_axi_bvalid = r_q.bvalid;
	assign s_axi_bresp = r_q.bresp;
	assign s_axi_arready = r_q.arready;
	assign s_axi_rvalid = r_q.rvalid;
	assign s_axi_rdata = r_q.rdata;
	assign s_axi_rresp = r_q.rresp;
	assign cpu_clock_enable = r_q.cpu_en;
	assign periph_clock_enable = r_q.per_en;
	assign system_clock_select = r_q.clk_sel;
	assign primary_osc_enable = r_q.pri_en;
	assign secondary_osc_enable = r_q.sec_en;
	assign high_freq_internal_enable = r_q.hf_en;
	assign low_freq_internal_enable = r_q.lf_en;
	// frequency field goes straight out of its register, no staging
	assign internal_freq_out = r_q.internal_freq_select;
	assign medium_source_out = r_q.medium_source_select;
endmodule : pmcs_top

// File: tb/pmcs_checker_sva.sv
`timescale 1ns/10ps
module pmcs_checker (
	input wire logic clock,
	input wire logic rstn,
	input wire logic sleep_exec,
	input wire logic wake_event,
	input wire logic cpu_clock_enable,
	input wire logic periph_clock_enable,
	input wire logic [1:0] system_clock_select,
	input wire logic secondary_osc_enable,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// switch gap: both enables low three cycles, back with the new source
	sequence gap_s;
		!periph_clock_enable [*3] ##1 (periph_clock_enable && $changed(system_clock_select));
	endsequence
	AST_SWITCH_GAP: assert property (cpu_clock_enable && !sleep_exec ##1 !periph_clock_enable |-> gap_s)
		else $error("clock switch gap wrong");
	AST_SLEEP_STOP: assert property (sleep_exec && cpu_clock_enable |=> !cpu_clock_enable)
		else $error("sleep did not stop cpu clock");
	AST_RUN_BOTH: assert property (cpu_clock_enable |-> periph_clock_enable)
		else $error("cpu clocked without peripherals");
	AST_HALT_WAKE: assert property (!cpu_clock_enable && periph_clock_enable && wake_event |=> cpu_clock_enable)
		else $error("halt did not wake");
	AST_SEC_RUNS: assert property (system_clock_select == 2'h1 |-> secondary_osc_enable)
		else $error("secondary oscillator off while selected");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
endmodule : pmcs_checker

// File: tb/pmcs_osc_model.sv
`timescale 1ns/10ps
module pmcs_osc_model #(parameter int START_CYCLES = 20) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic primary_osc_enable,
	input wire logic secondary_osc_enable,
	output logic primary_osc_ready,
	output logic secondary_osc_ready
);
	int pri_cnt;
	int sec_cnt;
	// ready only after a start-up delay, lost at once when stopped
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pri_cnt <= 0;
			sec_cnt <= 0;
		end else begin
			pri_cnt <= primary_osc_enable ? pri_cnt + int'(pri_cnt < START_CYCLES) : 0;
			sec_cnt <= secondary_osc_enable ? sec_cnt + int'(sec_cnt < START_CYCLES) : 0;
		end
	end
	assign primary_osc_ready = (pri_cnt == START_CYCLES);
	assign secondary_osc_ready = (sec_cnt == START_CYCLES);
endmodule : pmcs_osc_model

// File: tb/power_mode_clock_select_test.sv
`timescale 1ns/10ps
module power_mode_clock_select_test;
	import pmcs_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, system_clock_select;
	logic [31:0] s_axi_rdata, d;
	logic [1:0] r;
	logic sleep_exec = 1'b0, wake_event = 1'b0, primary_osc_ready, secondary_osc_ready;
	logic cpu_clock_enable, periph_clock_enable, primary_osc_enable, secondary_osc_enable;
	logic high_freq_internal_enable, low_freq_internal_enable, medium_source_out;
	logic [2:0] internal_freq_out;
	int num_errors = 0, compares = 0;
	always #20 clock = ~clock;
	pmcs_top pmcs_top_i (.clock(clock), .rstn(rstn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .sleep_exec(sleep_exec), .wake_event(wake_event),
		.primary_osc_ready(primary_osc_ready), .secondary_osc_ready(secondary_osc_ready),
		.cpu_clock_enable(cpu_clock_enable), .periph_clock_enable(periph_clock_enable),
		.system_clock_select(system_clock_select),
		.primary_osc_enable(primary_osc_enable),
		.secondary_osc_enable(secondary_osc_enable),
		.high_freq_internal_enable(high_freq_internal_enable),
		.low_freq_internal_enable(low_freq_internal_enable),
		.internal_freq_out(internal_freq_out), .medium_source_out(medium_source_out));
	pmcs_osc_model pmcs_osc_model_i (.clock(clock), .rstn(rstn),
		.primary_osc_enable(primary_osc_enable), .secondary_osc_enable(secondary_osc_enable),
		.primary_osc_ready(primary_osc_ready), .secondary_osc_ready(secondary_osc_ready));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic wait_sel(input logic [1:0] v);
		for (int n = 0; n < 300 && !(system_clock_select === v && cpu_clock_enable === 1'b1); n++)
			@(posedge clock);
	endtask : wait_sel
	task automatic pulse(input logic sleep);
		@(posedge clock);
		sleep_exec <= sleep;
		wake_event <= !sleep;
		@(posedge clock);
		sleep_exec <= 1'b0;
		wake_event <= 1'b0;
		#1;
	endtask : pulse
	task automatic finish_test;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk(32'({cpu_clock_enable, periph_clock_enable, primary_osc_enable}), 32'h7);
		axi_rd(8'h0c, d, r); chk(d, 32'h1);
		repeat (30) @(posedge clock);
		axi_wr(8'h00, 8'h52, r); chk(32'(internal_freq_out), 32'h5);
		wait_sel(SRC_INT); chk(32'({primary_osc_enable, system_clock_select}), 32'h2);
		repeat (60) @(posedge clock);
		axi_rd(8'h00, d, r); chk(d, 32'h56);
		axi_wr(8'h00, 8'h50, r); wait_sel(SRC_PRI);
		axi_rd(8'h00, d, r); chk(d, 32'h58);
		axi_wr(8'h00, 8'h51, r); repeat (40) @(posedge clock);
		chk(32'(system_clock_select), 32'h0);
		axi_wr(8'h04, 8'h08, r); wait_sel(SRC_SEC);
		chk(32'({primary_osc_enable, secondary_osc_enable}), 32'h1);
		axi_rd(8'h04, d, r); chk(d, 32'h48);
		axi_wr(8'h00, 8'hd1, r); pulse(1'b1);
		chk(32'({cpu_clock_enable, periph_clock_enable}), 32'h1);
		pulse(1'b0); chk(32'(cpu_clock_enable), 32'h1);
		axi_wr(8'h00, 8'h51, r); pulse(1'b1);
		chk(32'({cpu_clock_enable, periph_clock_enable}), 32'h0);
		pulse(1'b0);
		axi_wr(8'h00, 8'h02, r); wait_sel(SRC_INT);
		chk(32'({high_freq_internal_enable, low_freq_internal_enable}), 32'h1);
		axi_rd(8'h00, d, r); chk(d, 32'h2);
		axi_wr(8'h08, 8'h04, r); axi_wr(8'h00, 8'h00, r); wait_sel(SRC_PRI);
		chk(32'(low_freq_internal_enable), 32'h1);
		axi_rd(8'h00, d, r); chk(d, 32'h8);
		axi_wr(8'h04, 8'h18, r); axi_wr(8'h00, 8'h52, r); wait_sel(SRC_INT);
		axi_rd(8'h04, d, r); chk(d, 32'h18);
		repeat (60) @(posedge clock);
		axi_rd(8'h04, d, r); chk(d, 32'h1a);
		chk(32'({high_freq_internal_enable, medium_source_out}), 32'h3);
		axi_wr(8'h00, 8'h50, r); wait_sel(SRC_PRI);
		axi_wr(8'h00, 8'h52, r); wait_sel(SRC_INT);
		axi_rd(8'h04, d, r); chk(d, 32'h1a);
		axi_rd(8'h40, d, r); chk({d[29:0], r}, 32'h2);
		axi_wr(8'h40, 8'h01, r); chk(32'(r), 32'(RESP_SLVERR));
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		finish_test();
	end
endmodule : power_mode_clock_select_test
bind pmcs_top pmcs_checker pmcs_checker_i (.clock(clock), .rstn(rstn), .sleep_exec(sleep_exec),
	.wake_event(wake_event), .cpu_clock_enable(cpu_clock_enable),
	.periph_clock_enable(periph_clock_enable), .system_clock_select(system_clock_select),
	.secondary_osc_enable(secondary_osc_enable), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready));
